// ===== rtl/uar_cfg.svh
// register map, fields, reset values and timing counts of the async receiver
//
// Contract
// - sample receive pin at sixteen times baud
// - shift register advances once per bit
// - receive only while continuous receive enabled
// - stop bit moves character into fifo
// - transfer into fifo sets receive flag
// - receive-flag interrupt only while rie set; event interrupts need only their ien bit
// - flag read-only, cleared when fifo empty
// - two-entry fifo plus shifting third character
// - full fifo at stop sets overrun, drops
// - overrun cleared only by enable toggle
// - overrun blocks all transfers into fifo; reads still drain it
// - stop bit zero sets framing error
// - framing and ninth bit stored per entry
`ifndef UAR_CFG_SVH
`define UAR_CFG_SVH
`define UAR_CTRL_ADDR      12'h000
`define UAR_DATA_ADDR      12'h004
`define UAR_FLAG_ADDR      12'h008
`define UAR_IEN_ADDR       12'h00C
`define UAR_ICLR_ADDR      12'h010
`define UAR_BAUD_ADDR      12'h014
`define UAR_OVERRUN_ERROR_BIT       1
`define UAR_FRAMING_ERROR_BIT       2
`define UAR_CONTINUOUS_RECEIVE_ENABLE_BIT       4
`define UAR_RX9_BIT        6
`define UAR_NINTH_RECEIVED_BIT_BIT       0
`define UAR_RCV_FLAG_BIT   5
`define UAR_EV_OVR_BIT     1
`define UAR_EV_FRM_BIT     2
`define UAR_OVERSAMPLE     16
`define UAR_MID_TICK       4'h7
`define UAR_BAUD_RESET     16'h0035
`endif

// ===== rtl/uar_pkg.sv
// types of the async receiver
package uar_pkg;
  typedef enum logic [3:0] {
    UAR_IDLE  = 4'b0001,
    UAR_START = 4'b0010,
    UAR_DATA  = 4'b0100,
    UAR_STOP  = 4'b1000
  } uar_state_type;
  typedef logic [31:0] uar_word_type;
endpackage : uar_pkg

// ===== rtl/uar_receiver.sv
// async serial receiver with two-entry fifo and apb registers
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "uar_cfg.svh"
module uar_receiver #(
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire uar_pkg::uar_word_type pwdata,
  output uar_pkg::uar_word_type  prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              receive_input_pin,
  output logic                   irq
);
  import uar_pkg::*;

  // register state
  logic              continuous_receive_enable_q, continuous_receive_enable_d;
  logic              rx9_q, rx9_d;
  logic              rie_q, rie_d;
  logic [15:0]       baud_q, baud_d;
  logic [2:0]        ien_q, ien_d;
  logic [2:0]        evt_q, evt_d;
  logic              overrun_error_q, overrun_error_d;
  logic [10:0]       mem_q [FIFO_DEPTH];
  logic [10:0]       mem_d [FIFO_DEPTH];
  logic [1:0]        cnt_q, cnt_d;
  logic              rdp_q, rdp_d;
  logic              wrp_q, wrp_d;
  uar_word_type      prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  logic              irq_q, irq_d;
  // receiver state
  uar_state_type     st_q, st_d;
  logic [15:0]       div_q, div_d;
  logic [3:0]        tick_q, tick_d;
  logic [3:0]        bit_q, bit_d;
  logic [8:0]        shreg_q, shreg_d;
  logic              pin_q;

  logic acc, wr, rd, os_tick, done, stop_val, push, data_rd;
  logic [10:0] head;

  assign acc     = psel && penable && !pready_q;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign data_rd = rd && (paddr == `UAR_DATA_ADDR);
  assign head    = mem_q[rdp_q];
  assign os_tick = (div_q == 16'h0000);

  // receive machine
  always_comb begin
    st_d     = st_q;
    div_d    = os_tick ? baud_q : div_q - 16'h0001;
    tick_d   = tick_q;
    bit_d    = bit_q;
    shreg_d  = shreg_q;
    done     = 1'b0;
    stop_val = 1'b0;
    // receive only when enabled; disable resets receive logic
    if (!continuous_receive_enable_q) begin
      st_d   = UAR_IDLE;
      div_d  = baud_q;
      tick_d = 4'h0;
    end else if (os_tick) begin
      tick_d = tick_q + 4'h1;
      unique case (st_q)
        UAR_IDLE: begin
          tick_d = 4'h0;
          if (!pin_q) st_d = UAR_START;
        end
        UAR_START: begin
          if (tick_q == `UAR_MID_TICK) begin
            tick_d = 4'h0;
            bit_d  = 4'h0;
            st_d   = pin_q ? UAR_IDLE : UAR_DATA;
          end
        end
        UAR_DATA: begin
          if (tick_q == 4'hF) begin
            shreg_d = {pin_q, shreg_q[8:1]};
            bit_d   = bit_q + 4'h1;
            if (bit_q == (rx9_q ? 4'h8 : 4'h7)) st_d = UAR_STOP;
          end
        end
        UAR_STOP: begin
          if (tick_q == 4'hF) begin
            done     = 1'b1;
            stop_val = pin_q;
            st_d     = UAR_IDLE;
          end
        end
        default: st_d = UAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= UAR_IDLE;
      div_q   <= 16'h0000;
      tick_q  <= 4'h0;
      bit_q   <= 4'h0;
      shreg_q <= 9'h000;
      pin_q   <= 1'b1;
    end else begin
      st_q    <= st_d;
      div_q   <= div_d;
      tick_q  <= tick_d;
      bit_q   <= bit_d;
      shreg_q <= shreg_d;
      pin_q   <= receive_input_pin;
    end
  end

  // push when room; blocked by overrun
  assign push = done && !overrun_error_q && (cnt_q != 2'(FIFO_DEPTH));

  // fifo, flags and apb
  always_comb begin
    logic [8:0] ch;
    ch = rx9_q ? shreg_q : {1'b0, shreg_q[8:1]};
    continuous_receive_enable_d = continuous_receive_enable_q;
    rx9_d  = rx9_q;
    rie_d  = rie_q;
    baud_d = baud_q;
    ien_d  = ien_q;
    evt_d  = evt_q;
    overrun_error_d = overrun_error_q;
    mem_d  = mem_q;
    cnt_d  = cnt_q;
    rdp_d  = rdp_q;
    wrp_d  = wrp_q;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    pready_d  = acc;
    if (wr) begin
      unique case (paddr)
        `UAR_CTRL_ADDR: begin
          continuous_receive_enable_d = pwdata[`UAR_CONTINUOUS_RECEIVE_ENABLE_BIT];
          rx9_d  = pwdata[`UAR_RX9_BIT];
          // clearing enable resets receive logic and overrun
          if (!pwdata[`UAR_CONTINUOUS_RECEIVE_ENABLE_BIT]) overrun_error_d = 1'b0;
        end
        `UAR_FLAG_ADDR: rie_d = pwdata[`UAR_RCV_FLAG_BIT];
        `UAR_IEN_ADDR:  ien_d = pwdata[2:0];
        `UAR_ICLR_ADDR: evt_d = evt_q & ~pwdata[2:0];
        `UAR_BAUD_ADDR: baud_d = pwdata[15:0];
        `UAR_DATA_ADDR: ;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        // status shows head entry's framing and ninth bit
        `UAR_CTRL_ADDR: begin
          prdata_d[`UAR_CONTINUOUS_RECEIVE_ENABLE_BIT] = continuous_receive_enable_q;
          prdata_d[`UAR_RX9_BIT]  = rx9_q;
          prdata_d[`UAR_OVERRUN_ERROR_BIT] = overrun_error_q;
          prdata_d[`UAR_FRAMING_ERROR_BIT] = (cnt_q != 2'h0) && head[10];
          prdata_d[`UAR_NINTH_RECEIVED_BIT_BIT] = (cnt_q != 2'h0) && head[8];
        end
        `UAR_DATA_ADDR: prdata_d[7:0] = head[7:0];
        // flag is read-only, mirrors nonempty fifo
        `UAR_FLAG_ADDR: prdata_d[`UAR_RCV_FLAG_BIT] = (cnt_q != 2'h0);
        `UAR_IEN_ADDR:  prdata_d = {29'h0, evt_q};
        `UAR_BAUD_ADDR: prdata_d = {16'h0, baud_q};
        `UAR_ICLR_ADDR: ;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (data_rd && cnt_q != 2'h0) begin
      rdp_d = ~rdp_q;
      cnt_d = cnt_d - 2'h1;
    end
    // stop zero marks framing error in entry
    if (push) begin
      mem_d[wrp_q] = {~stop_val, 1'b0, ch};
      wrp_d = ~wrp_q;
      cnt_d = cnt_d + 2'h1;
      evt_d[0] = 1'b1;
    end
    if (done && !stop_val) evt_d[`UAR_EV_FRM_BIT] = 1'b1;
    // full fifo at stop: overrun, character lost
    if (done && !overrun_error_q && cnt_q == 2'(FIFO_DEPTH)) begin
      overrun_error_d = 1'b1;
      evt_d[`UAR_EV_OVR_BIT] = 1'b1;
    end
    // flag gated by enable; event bits by enable reg
    irq_d = (rie_q && cnt_d != 2'h0) || |(evt_d & ien_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      continuous_receive_enable_q <= 1'b0;
      rx9_q  <= 1'b0;
      rie_q  <= 1'b0;
      baud_q <= `UAR_BAUD_RESET;
      ien_q  <= 3'h0;
      evt_q  <= 3'h0;
      overrun_error_q <= 1'b0;
      mem_q  <= '{default: 11'h000};
      cnt_q  <= 2'h0;
      rdp_q  <= 1'b0;
      wrp_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      continuous_receive_enable_q <= continuous_receive_enable_d;
      rx9_q  <= rx9_d;
      rie_q  <= rie_d;
      baud_q <= baud_d;
      ien_q  <= ien_d;
      evt_q  <= evt_d;
      overrun_error_q <= overrun_error_d;
      mem_q  <= mem_d;
      cnt_q  <= cnt_d;
      rdp_q  <= rdp_d;
      wrp_q  <= wrp_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  overrun_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_error_q |=> $stable(wrp_q) || !overrun_error_q)
    else $error("fifo written during overrun");
  overrun_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (done && cnt_q == 2'h2) |=> overrun_error_q)
    else $error("overrun not set");
  push_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (push && !data_rd) |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("push lost");
  fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_q <= 2'h2)
    else $error("fifo overfilled");
  disabled_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !continuous_receive_enable_q |=> st_q == UAR_IDLE)
    else $error("receiving while disabled");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!rie_q && ien_q == 3'h0) [*2] |-> !irq_q)
    else $error("irq without enable");
  frame_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (done && !stop_val) |=> evt_q[`UAR_EV_FRM_BIT])
    else $error("framing event missing");
  overrun_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `UAR_CTRL_ADDR && !pwdata[`UAR_CONTINUOUS_RECEIVE_ENABLE_BIT]) |=> !overrun_error_q)
    else $error("overrun not cleared");
  start_mid_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == UAR_START && st_d == UAR_DATA) |-> !pin_q)
    else $error("start bit not low at mid");
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc |=> pready_q ##1 !pready_q)
    else $error("apb answer not one cycle");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (data_rd && cnt_q == 2'h1 && !push) |=> cnt_q == 2'h0)
    else $error("flag stays after last read");
  rcv_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rie_q && push) |=> irq_q)
    else $error("receive irq missing");
  start_glitch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == UAR_START && os_tick && tick_q == `UAR_MID_TICK && pin_q) |=> st_q == UAR_IDLE)
    else $error("false start not rejected");

  char_c: cover property (@(posedge pclk) disable iff (!presetn) push);
  full_c: cover property (@(posedge pclk) disable iff (!presetn) cnt_q == 2'h2);
  ovr_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(overrun_error_q));
  frm_c: cover property (@(posedge pclk) disable iff (!presetn) done && !stop_val);
  nine_c: cover property (@(posedge pclk) disable iff (!presetn) rx9_q && push);
endmodule : uar_receiver

// ===== test/uar_line_source.sv
// remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
module uar_line_source #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic pclk,
  output logic      line
);
  // idle high until the first frame
  initial line = 1'b1;
  task automatic send(input logic [8:0] data, input logic nine, input logic stop);
    logic [10:0] bits;
    int          n;
    bits = {stop, data, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) bits[9] = stop;
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
    line <= 1'b1;
    // one idle bit so the receiver rearms before the next start
    repeat (BIT_CYCLES) @(posedge pclk);
  endtask : send
endmodule : uar_line_source

// ===== test/uart_async_receiver_test.sv
// self-checking bench for the async receiver
`timescale 1ns/1ps
`include "uar_cfg.svh"
module uart_async_receiver_test;
  import uar_pkg::*;
  logic         pclk    = 1'b0;
  logic         presetn = 1'b0;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [11:0]  paddr   = 12'h000;
  uar_word_type pwdata  = '0;
  uar_word_type prdata;
  uar_word_type rd;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic         rx_line;
  logic         err_seen;
  int           fail_count = 0;
  int           checked    = 0;
  // bit 8 is the stop bit level, low means a framing fault
  logic [8:0]   rows [4]   = '{9'h1A5, 9'h101, 9'h080, 9'h1FF};

  always #5 pclk = ~pclk;

  uar_receiver #(.FIFO_DEPTH(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_input_pin(rx_line), .irq(irq));
  // baud divisor 0 gives sixteen pclk per bit
  uar_line_source #(.BIT_CYCLES(16)) src (.pclk(pclk), .line(rx_line));

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input uar_word_type exp, input uar_word_type got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_irq(input logic exp);
    checked++;
    if (irq !== exp) begin
      fail_count++;
      $display("wrong value irq expected %b seen %b", exp, irq);
    end
  endtask : chk_irq

  task automatic apb(input logic w, input logic [11:0] a, input uar_word_type d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input uar_word_type exp, input string what);
    apb(1'b0, a, '0);
    chk(what, exp, rd);
  endtask : rdchk

  // hang guard, well past the expected run length
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_irq(1'b0);
    rdchk(`UAR_BAUD_ADDR, {16'h0, `UAR_BAUD_RESET}, "baud");
    apb(1'b1, `UAR_BAUD_ADDR, '0);
    apb(1'b1, `UAR_FLAG_ADDR, 32'h0000_0020);
    apb(1'b1, `UAR_CTRL_ADDR, 32'h0000_0010);
    foreach (rows[i]) begin
      src.send({1'b0, rows[i][7:0]}, 1'b0, rows[i][8]);
      chk_irq(1'b1);
      rdchk(`UAR_CTRL_ADDR, rows[i][8] ? 32'h10 : 32'h14, "status");
      rdchk(`UAR_DATA_ADDR, {24'h0, rows[i][7:0]}, "data");
      rdchk(`UAR_FLAG_ADDR, '0, "flag");
      chk_irq(1'b0);
    end
    src.send(9'h011, 1'b0, 1'b1);
    src.send(9'h022, 1'b0, 1'b1);
    src.send(9'h033, 1'b0, 1'b1);
    rdchk(`UAR_CTRL_ADDR, 32'h12, "overrun");
    rdchk(`UAR_DATA_ADDR, 32'h11, "first");
    src.send(9'h044, 1'b0, 1'b1);
    rdchk(`UAR_DATA_ADDR, 32'h22, "second");
    rdchk(`UAR_FLAG_ADDR, '0, "blocked");
    apb(1'b1, `UAR_CTRL_ADDR, '0);
    rdchk(`UAR_CTRL_ADDR, '0, "cleared");
    src.send(9'h066, 1'b0, 1'b1);
    rdchk(`UAR_FLAG_ADDR, '0, "disabled");
    apb(1'b1, `UAR_CTRL_ADDR, 32'h10);
    src.send(9'h077, 1'b0, 1'b1);
    rdchk(`UAR_DATA_ADDR, 32'h77, "resumed");
    apb(1'b1, `UAR_CTRL_ADDR, 32'h50);
    src.send(9'h13C, 1'b1, 1'b1);
    src.send(9'h0C3, 1'b1, 1'b0);
    rdchk(`UAR_CTRL_ADDR, 32'h51, "ninth");
    rdchk(`UAR_DATA_ADDR, 32'h3C, "data9");
    rdchk(`UAR_CTRL_ADDR, 32'h54, "next status");
    rdchk(`UAR_DATA_ADDR, 32'hC3, "data9b");
    apb(1'b1, `UAR_CTRL_ADDR, 32'h10);
    apb(1'b1, `UAR_FLAG_ADDR, '0);
    apb(1'b1, `UAR_ICLR_ADDR, 32'h7);
    apb(1'b1, `UAR_IEN_ADDR, 32'h4);
    src.send(9'h05A, 1'b0, 1'b1);
    chk_irq(1'b0);
    rdchk(`UAR_FLAG_ADDR, 32'h20, "flag masked");
    apb(1'b1, `UAR_FLAG_ADDR, 32'h20);
    rdchk(`UAR_IEN_ADDR, 32'h1, "events");
    chk_irq(1'b1);
    rdchk(`UAR_DATA_ADDR, 32'h5A, "data ev");
    apb(1'b1, `UAR_FLAG_ADDR, '0);
    src.send(9'h0AA, 1'b0, 1'b0);
    chk_irq(1'b1);
    rdchk(`UAR_IEN_ADDR, 32'h5, "frame event");
    apb(1'b1, `UAR_ICLR_ADDR, 32'h4);
    rdchk(`UAR_DATA_ADDR, 32'hAA, "data fe");
    chk_irq(1'b0);
    // mid-run reset with a character waiting and its irq up
    apb(1'b1, `UAR_FLAG_ADDR, 32'h0000_0020);
    src.send(9'h055, 1'b0, 1'b1);
    chk_irq(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_irq(1'b0);
    rdchk(`UAR_FLAG_ADDR, '0, "flag after reset");
    rdchk(`UAR_BAUD_ADDR, {16'h0, `UAR_BAUD_RESET}, "baud after reset");
    rdchk(`UAR_CTRL_ADDR, '0, "ctrl after reset");
    apb(1'b0, 12'h020, '0);
    chk("slverr", 32'h1, {31'b0, err_seen});
    end_of_test();
  end
endmodule : uart_async_receiver_test
